// ==== flash_host.sv ====
// host sequencer driving a byte-wide flash over its control, address and data pins
// assumes one 25 MHz clock; dq inputs from the pins are double-synchronised here
`timescale 1ns/1ps
module flash_host
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // request side
  input wire logic req_valid_in,
  input wire flash_host_pkg::req_t req_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [7:0] rdata_out,
  // flash pins
  output flash_host_pkg::pins_t pins_out,
  input wire logic [7:0] dq_in
);
  localparam int CW = 4;

  typedef enum logic [2:0] {S_IDLE, S_SETUP, S_WLOW, S_WHIGH, S_RLOW, S_RHOLD, S_POLL}
    phase_t;

  typedef struct packed {
    phase_t phase;
    flash_host_pkg::req_t req;
    logic [2:0] step;
    logic [CW-1:0] cnt;
    logic polling;
    logic have_prev;
    logic prev_tog;
    flash_host_pkg::pins_t pins;
    logic done;
    logic [7:0] rdata;
    logic [7:0] dq_s1;
    logic [7:0] dq_s2;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // the strobe counter must reach WE_LOW_CYC and the read counter READ_CYC + 1 within CW bits
  if (flash_host_pkg::WE_LOW_CYC <= flash_host_pkg::GLITCH_CYC || flash_host_pkg::WE_LOW_CYC >= 15
      || flash_host_pkg::READ_CYC >= 15)
  begin : g_bad_timing
    $error("flash_host: pulse widths not servable");
  end

  // command sequence tables: number of cycles and each cycle's address and data
  function automatic logic [2:0] seq_len(input flash_host_pkg::op_t op);
    unique case (op)
      flash_host_pkg::OP_PROGRAM: seq_len = 3'd4;
      flash_host_pkg::OP_SECTOR_ERASE, flash_host_pkg::OP_CHIP_ERASE: seq_len = 3'd6;
      flash_host_pkg::OP_ID_ENTRY: seq_len = 3'd3;
      flash_host_pkg::OP_ID_EXIT: seq_len = 3'd1;
      default: seq_len = 3'd0;
    endcase
  endfunction

  function automatic logic [18:0] seq_addr(input flash_host_pkg::req_t r, input logic [2:0] s);
    logic last;
    last = (s == seq_len(r.op) - 3'd1);
    seq_addr = 19'h00000;
    if (r.op == flash_host_pkg::OP_ID_EXIT)
      seq_addr = 19'h00000;
    else if (last && r.op == flash_host_pkg::OP_PROGRAM)
      seq_addr = r.addr;
    else if (last && r.op == flash_host_pkg::OP_SECTOR_ERASE)
      seq_addr = {r.addr[18:12], 12'h000};
    else if (s == 3'd1 || s == 3'd4)
      seq_addr = {4'h0, flash_host_pkg::UNLOCK_ADDR2};
    else
      seq_addr = {4'h0, flash_host_pkg::UNLOCK_ADDR1};
  endfunction

  function automatic logic [7:0] seq_data(input flash_host_pkg::req_t r, input logic [2:0] s);
    logic last;
    last = (s == seq_len(r.op) - 3'd1);
    seq_data = flash_host_pkg::CMD_AA;
    if (last)
      unique case (r.op)
        flash_host_pkg::OP_PROGRAM: seq_data = r.data;
        flash_host_pkg::OP_SECTOR_ERASE: seq_data = flash_host_pkg::CMD_SECTOR_ERASE;
        flash_host_pkg::OP_CHIP_ERASE: seq_data = flash_host_pkg::CMD_CHIP_ERASE;
        flash_host_pkg::OP_ID_ENTRY: seq_data = flash_host_pkg::CMD_ID_ENTRY;
        flash_host_pkg::OP_ID_EXIT: seq_data = flash_host_pkg::CMD_ID_EXIT;
        default: seq_data = 8'h00;
      endcase
    else if (s == 3'd1 || s == 3'd4)
      seq_data = flash_host_pkg::CMD_55;
    else if (s == 3'd2 && r.op == flash_host_pkg::OP_PROGRAM)
      seq_data = flash_host_pkg::CMD_PROGRAM;
    else if (s == 3'd2)
      seq_data = flash_host_pkg::CMD_ERASE_SETUP;
  endfunction

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.dq_s1 = dq_in;
    st_nxt.dq_s2 = st_r.dq_s1;
    unique case (st_r.phase)
      S_IDLE:
      begin
        st_nxt.pins.ce_n = 1'b1;
        st_nxt.pins.oe_n = 1'b1;
        st_nxt.pins.we_n = 1'b1;
        st_nxt.pins.dq_oe = 1'b0;
        if (req_valid_in)
        begin
          st_nxt.req = req_in;
          st_nxt.step = 3'd0;
          st_nxt.polling = 1'b0;
          st_nxt.have_prev = 1'b0;
          st_nxt.phase = (req_in.op == flash_host_pkg::OP_READ) ? S_RLOW : S_SETUP;
          st_nxt.cnt = '0;
        end
      end
      S_SETUP:
      begin
        // address and data settle with oe high before the strobe falls
        st_nxt.pins.ce_n = 1'b0;
        st_nxt.pins.oe_n = 1'b1;
        st_nxt.pins.we_n = 1'b1;
        st_nxt.pins.addr = seq_addr(st_r.req, st_r.step);
        st_nxt.pins.dq = seq_data(st_r.req, st_r.step);
        st_nxt.pins.dq_oe = 1'b1;
        st_nxt.cnt = '0;
        st_nxt.phase = S_WLOW;
      end
      S_WLOW:
      begin
        st_nxt.pins.we_n = 1'b0;
        st_nxt.cnt = st_r.cnt + 1'b1;
        // strobe falls one cycle after entry, so it stands low for WE_LOW_CYC full cycles
        if (st_r.cnt == CW'(flash_host_pkg::WE_LOW_CYC))
        begin
          st_nxt.pins.we_n = 1'b1;
          st_nxt.phase = S_WHIGH;
        end
      end
      S_WHIGH:
      begin
        // data held one more cycle past the rising strobe, then released
        st_nxt.pins.ce_n = 1'b1;
        st_nxt.pins.dq_oe = 1'b0;
        st_nxt.step = st_r.step + 3'd1;
        if (st_r.step + 3'd1 < seq_len(st_r.req.op))
          st_nxt.phase = S_SETUP;
        else if (st_r.req.op == flash_host_pkg::OP_PROGRAM
                 || st_r.req.op == flash_host_pkg::OP_SECTOR_ERASE
                 || st_r.req.op == flash_host_pkg::OP_CHIP_ERASE)
        begin
          st_nxt.polling = 1'b1;
          st_nxt.phase = S_RLOW;
          st_nxt.cnt = '0;
        end
        else
        begin
          st_nxt.done = 1'b1;
          st_nxt.phase = S_IDLE;
        end
      end
      S_RLOW:
      begin
        st_nxt.pins.ce_n = 1'b0;
        st_nxt.pins.oe_n = 1'b0;
        st_nxt.pins.we_n = 1'b1;
        st_nxt.pins.dq_oe = 1'b0;
        if (!st_r.polling)
          st_nxt.pins.addr = st_r.req.addr;
        st_nxt.cnt = st_r.cnt + 1'b1;
        // two extra cycles cover the input synchroniser latency
        if (st_r.cnt == CW'(flash_host_pkg::READ_CYC + 1))
          st_nxt.phase = S_RHOLD;
      end
      S_RHOLD:
      begin
        st_nxt.pins.ce_n = 1'b1;
        st_nxt.pins.oe_n = 1'b1;
        st_nxt.cnt = '0;
        st_nxt.rdata = st_r.dq_s2;
        if (!st_r.polling)
        begin
          st_nxt.done = 1'b1;
          st_nxt.phase = S_IDLE;
        end
        else
          st_nxt.phase = S_POLL;
        st_nxt.prev_tog = st_r.dq_s2[flash_host_pkg::TOGGLE_BIT];
        st_nxt.have_prev = 1'b1;
      end
      S_POLL:
      begin
        // busy while two successive reads disagree on the toggle bit; no new
        // command is issued meanwhile, so nothing lands on a busy flash
        if (st_r.have_prev && st_r.polling
            && st_r.rdata[flash_host_pkg::TOGGLE_BIT] == st_r.prev_tog
            && st_r.cnt == CW'(1))
        begin
          st_nxt.done = 1'b1;
          st_nxt.phase = S_IDLE;
        end
        else
        begin
          st_nxt.phase = S_RLOW;
        end
        st_nxt.cnt = '0;
      end
      default: st_nxt.phase = S_IDLE;
    endcase
    // track read pair: cnt in S_POLL means "second read of pair taken"
    if (st_r.phase == S_RHOLD && st_r.polling)
    begin
      st_nxt.cnt = st_r.have_prev ? CW'(1) : CW'(0);
      st_nxt.prev_tog = st_r.have_prev ? st_r.rdata[flash_host_pkg::TOGGLE_BIT]
                                        : st_r.dq_s2[flash_host_pkg::TOGGLE_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      st_r <= '0;
      st_r.phase <= S_IDLE;
      st_r.pins.ce_n <= 1'b1;
      st_r.pins.oe_n <= 1'b1;
      st_r.pins.we_n <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign req_ready_out = (st_r.phase == S_IDLE);
  assign done_out = st_r.done;
  assign rdata_out = st_r.rdata;
  assign pins_out = st_r.pins;

  a_write_inhibit_oe: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pins_out.we_n |-> (pins_out.oe_n && !pins_out.ce_n))
    else $error("write strobe low while oe low or ce high");
  a_no_drive_on_read: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !pins_out.oe_n |-> !pins_out.dq_oe)
    else $error("host drives dq during read");
  a_we_pulse_width: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(pins_out.we_n) |-> !pins_out.we_n [*2])
    else $error("write pulse too short");
  a_cs_for_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!pins_out.we_n || !pins_out.oe_n) |-> !pins_out.ce_n)
    else $error("bus cycle without chip select");
  a_data_held_edge: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(pins_out.we_n) |-> pins_out.dq_oe && $stable(pins_out.dq))
    else $error("data not held at rising strobe");
  a_exit_one_cycle: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (req_valid_in && req_ready_out && req_in.op == flash_host_pkg::OP_ID_EXIT)
    |-> ##[1:8] done_out)
    else $error("id exit not single cycle");
  a_first_unlock: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    ($fell(pins_out.we_n) && st_r.step == 3'd0 && st_r.req.op != flash_host_pkg::OP_ID_EXIT)
    |-> pins_out.dq == flash_host_pkg::CMD_AA)
    else $error("sequence not opened by unlock");
  a_poll_after_cmd: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (st_r.phase == S_WHIGH && st_r.polling == 1'b0 && st_r.step == 3'd3
     && st_r.req.op == flash_host_pkg::OP_PROGRAM) |=> st_r.polling)
    else $error("poll not started after fourth strobe");
  c_program: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    done_out && st_r.req.op == flash_host_pkg::OP_PROGRAM);
  c_erase: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    done_out && st_r.req.op == flash_host_pkg::OP_SECTOR_ERASE);
  c_read: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    done_out && st_r.req.op == flash_host_pkg::OP_READ);
endmodule

// ==== flash_host_pkg.sv ====
// constants and carrier types for the parallel flash command host
// assumes a byte-wide asynchronous flash with unlock command sequences
package flash_host_pkg;
  localparam int ADDR_W = 19;
  localparam int SECTOR_LSB = 12;
  localparam logic [14:0] UNLOCK_ADDR1 = 15'h5555;
  localparam logic [14:0] UNLOCK_ADDR2 = 15'h2AAA;
  localparam logic [7:0] CMD_AA = 8'hAA;
  localparam logic [7:0] CMD_55 = 8'h55;
  localparam logic [7:0] CMD_PROGRAM = 8'hA0;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
  localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
  localparam logic [7:0] CMD_ID_EXIT = 8'hF0;
  localparam int TOGGLE_BIT = 6;
  // timing at 25 MHz (40 ns); glitch threshold 5 ns, pulse widths rounded up
  localparam int CLK_PERIOD_NS = 40;
  localparam int GLITCH_NS = 5;
  localparam int WE_LOW_NS = 80;
  localparam int READ_NS = 120;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEQ_MAX = 6;

  typedef enum logic [2:0] {
    OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE, OP_ID_ENTRY, OP_ID_EXIT, OP_READ
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } req_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [ADDR_W-1:0] addr;
    logic [7:0] dq;
    logic dq_oe;
  } pins_t;
endpackage

// ==== flash_model.sv ====
// behavioural byte-wide flash that answers the host's registered pins
// assumes clk_in only paces the internal busy timer; busy length comes from the bench
`timescale 1ns/1ps
module flash_model
#(
  parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h4D // arbitrary value
)
(
  // timer clock
  input wire logic clk_in,
  // flash pins, plus the busy length from the bench
  input wire flash_host_pkg::pins_t pins_in,
  input wire logic [15:0] busy_cyc_in,
  output logic [7:0] dq_out,
  output logic dq_oe_out,
  // writes seen while busy or with dq undriven
  output int faults_out
);
  logic [7:0] mem [int];
  logic [18:0] a_lat;
  logic [7:0] last_r;
  logic [2:0] step;
  logic id_mode, prog_busy, tog;
  int busy;
  time fall_t;

  function automatic logic [7:0] rd(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // unlock protection is permanent: every change but the single-cycle F0 id exit walks this sequence
  task automatic command(input logic [18:0] a, input logic [7:0] d);
    logic h1, h2;
    h1 = a[14:0] == flash_host_pkg::UNLOCK_ADDR1;
    h2 = a[14:0] == flash_host_pkg::UNLOCK_ADDR2;
    case (step)
      3'd0: begin if (d == 8'hF0) id_mode = 1'b0; step = {2'b00, h1 && d == 8'hAA}; end
      3'd1: step = (h2 && d == 8'h55) ? 3'd2 : 3'd0;
      3'd2: begin
        step = (h1 && d == 8'hA0) ? 3'd3 : (h1 && d == 8'h80) ? 3'd4 : 3'd0;
        if (h1 && d == 8'h90) id_mode = 1'b1;
        if (h1 && d == 8'hF0) id_mode = 1'b0;
      end
      3'd3: begin mem[a] = rd(a) & d; last_r = d; prog_busy = 1'b1; busy = busy_cyc_in; step = 0; end
      3'd4: step = (h1 && d == 8'hAA) ? 3'd5 : 3'd0;
      3'd5: step = (h2 && d == 8'h55) ? 3'd6 : 3'd0;
      default: begin
        // only the top lines pick the sector; low bits of the address are ignored
        if (d == 8'h30) foreach (mem[k]) if (k[18:12] == a[18:12]) mem[k] = 8'hFF;
        if (d == 8'h10 && h1) mem.delete();
        if (d == 8'h30 || (d == 8'h10 && h1)) begin prog_busy = 1'b0; busy = busy_cyc_in; end
        step = 0;
      end
    endcase
  endtask

  initial
  begin
    step = 0; id_mode = 0; prog_busy = 0; tog = 0; busy = 0; faults_out = 0; fall_t = 0;
    last_r = 8'h00; a_lat = '0;
  end

  always @(negedge pins_in.we_n)
    if (!pins_in.ce_n)
    begin
      a_lat = pins_in.addr;
      fall_t = $time;
    end

  always @(posedge pins_in.we_n)
    if (!pins_in.ce_n && pins_in.oe_n && $time - fall_t >= 5)
      if (busy > 0 || !pins_in.dq_oe) faults_out++;
      else command(a_lat, pins_in.dq);

  always @(posedge clk_in)
    if (busy > 0) busy = busy - 1;

  // ce and oe move together on the host's registered pins, so each read while busy flips at its start
  always @(negedge pins_in.oe_n)
    if (!pins_in.ce_n && busy > 0) tog = ~tog;

  always @*
  begin
    dq_oe_out = !pins_in.ce_n && !pins_in.oe_n;
    if (busy > 0) dq_out = {prog_busy ? ~last_r[7] : 1'b0, tog, last_r[5:0]};
    else if (id_mode) dq_out = pins_in.addr[0] ? DEVICE_ID : MAKER_ID;
    else dq_out = rd(pins_in.addr);
  end
endmodule

// ==== flash_host_bench.sv ====
// self-checking bench: the flash command host against the behavioural flash
// assumes the package and flash_model are compiled first
`timescale 1ns/1ps
module flash_host_bench;
  typedef struct packed { logic chk; logic [7:0] val; } note_t;
  logic clk_in, rst_n_in, req_valid_in, req_ready_out, done_out, f_oe, flt;
  flash_host_pkg::req_t req_in;
  flash_host_pkg::pins_t pins_out;
  logic [7:0] rdata_out, dq_in, f_dq;
  logic [15:0] busy_cyc;
  logic [18:0] a;
  int faults, fails, comparisons, seed;
  note_t notes[$];
  note_t nt;
  logic [7:0] shadow [int];

  flash_host dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .done_out(done_out),
    .rdata_out(rdata_out), .pins_out(pins_out), .dq_in(dq_in));
  flash_model model (.clk_in(clk_in), .pins_in(pins_out), .busy_cyc_in(busy_cyc),
    .dq_out(f_dq), .dq_oe_out(f_oe), .faults_out(faults));

  // a released bus shows a pattern that flips every cycle, never a stale byte
  assign dq_in = f_oe ? f_dq : (pins_out.dq_oe ? pins_out.dq : {8{flt}});

  initial
  begin
    clk_in = 0;
    flt = 0;
    forever #20 clk_in = ~clk_in;
  end
  always @(posedge clk_in) flt <= ~flt;

  task automatic close_out;
    if (fails == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_count(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp)
    begin
      fails++;
      $display("wrong value %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  function automatic logic [7:0] sh(input logic [18:0] x);
    return shadow.exists(x) ? shadow[x] : 8'hFF;
  endfunction

  task automatic op(input flash_host_pkg::op_t o, input logic [18:0] x, input logic [7:0] d,
                    input logic chk, input logic [7:0] exp);
    int n;
    n = 0;
    notes.push_back({chk, exp});
    @(negedge clk_in);
    busy_cyc = 16'($random(seed)) & 16'h00FF;
    req_in = '{op: o, addr: x, data: d};
    req_valid_in = 1'b1;
    while (!req_ready_out && n < 1000) begin @(negedge clk_in); n++; end
    if (n == 1000) fails++;
    @(negedge clk_in);
    req_valid_in = 1'b0;
    n = 0;
    while (notes.size() > 0 && n < 20000) begin @(negedge clk_in); n++; end
    if (n == 20000) fails++;
  endtask

  task automatic prog(input logic [18:0] x, input logic [7:0] d);
    op(flash_host_pkg::OP_PROGRAM, x, d, 1'b0, 8'h00);
    shadow[x] = sh(x) & d;
  endtask

  task automatic rd(input logic [18:0] x);
    op(flash_host_pkg::OP_READ, x, 8'h00, 1'b1, sh(x));
  endtask

  always @(negedge clk_in)
  begin
    if (f_oe && pins_out.dq_oe) check_count("dq contention", 0, 1);
    if (rst_n_in && done_out === 1'b1)
      if (notes.size() == 0) check_count("spare done", 0, 1);
      else
      begin
        nt = notes.pop_front();
        if (nt.chk) check_byte("read data", nt.val, rdata_out);
      end
  end

  initial
  begin
    repeat (80000) @(posedge clk_in);
    fails++;
    close_out;
  end

  initial
  begin
    seed = 95; fails = 0; comparisons = 0; rst_n_in = 0; req_valid_in = 0;
    req_in = '0; busy_cyc = 0;
    repeat (16) @(negedge clk_in);
    rst_n_in = 1;
    op(flash_host_pkg::OP_ID_ENTRY, 19'h0, 8'h00, 1'b0, 8'h00);
    op(flash_host_pkg::OP_READ, 19'h0, 8'h00, 1'b1, 8'h3C);
    op(flash_host_pkg::OP_READ, 19'h1, 8'h00, 1'b1, 8'h4D);
    op(flash_host_pkg::OP_ID_EXIT, 19'h0, 8'h00, 1'b0, 8'h00);
    rd(19'h0);
    prog(19'h00000, 8'h5A);
    prog(19'h7FFFF, 8'hA5);
    rd(19'h00000);
    rd(19'h7FFFF);
    repeat (12)
    begin
      a = 19'($random(seed));
      prog(a, 8'($random(seed)));
      rd(a);
    end
    prog(19'h23FFF, 8'h00);
    prog(19'h24000, 8'h00);
    prog(19'h24FFF, 8'h11);
    op(flash_host_pkg::OP_SECTOR_ERASE, 19'h24ABC, 8'h00, 1'b0, 8'h00);
    foreach (shadow[k]) if (k[18:12] == 7'h24) shadow[k] = 8'hFF;
    rd(19'h23FFF);
    rd(19'h24000);
    rd(19'h24FFF);
    op(flash_host_pkg::OP_CHIP_ERASE, 19'h0, 8'h00, 1'b0, 8'h00);
    shadow.delete();
    rd(19'h23FFF);
    rd(a);
    check_count("model faults", 0, faults);
    close_out;
  end
endmodule
